// [bbce_pkg.sv]
// constants, types and helpers of the bit/branch/call/clear execution block
`default_nettype none
package bbce_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_SRC    = 6'h08;
    localparam logic [5:0] OFS_DST    = 6'h0c;
    localparam logic [5:0] OFS_RESULT = 6'h10;
    localparam logic [5:0] OFS_STREG  = 6'h14;
    localparam logic [5:0] OFS_PC     = 6'h18;
    localparam logic [5:0] OFS_SP     = 6'h1c;
    localparam logic [5:0] OFS_TOS    = 6'h20;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_OP_LSB  = 0;
    localparam int CTL_OP_MSB  = 2;
    localparam int CTL_BYTE    = 3;
    localparam int ST_BUSY     = 0;
    localparam int ST_DONE     = 1;
    localparam int SR_C        = 0;
    localparam int SR_Z        = 1;
    localparam int SR_N        = 2;
    localparam int SR_GIE      = 3;
    localparam int SR_CORE_OFF = 4;
    localparam int SR_OSC_OFF  = 5;
    localparam int SR_V        = 8;
    localparam int BYTE_MSB    = 7;
    localparam int WORD_MSB    = 15;

    // ****************************************
    // values
    // ****************************************
    localparam logic [15:0] REG_RST    = 16'h0000;
    localparam logic [15:0] CARRY_MASK = 16'h0001;
    localparam logic [15:0] NEG_MASK   = 16'h0004;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] WORD_MASK  = 16'hffff;
    localparam logic [15:0] BYTE_MASK  = 16'h00ff;
    localparam logic [11:0] CTL_PAD    = 12'h000;
    localparam logic [13:0] STAT_PAD   = 14'h0000;

    typedef enum logic [2:0] {
        clear_bits_op       = 3'h0,
        set_bits_op         = 3'h1,
        test_bits_op        = 3'h2,
        branch_op           = 3'h3,
        call_op             = 3'h4,
        zero_destination_op = 3'h5,
        clear_carry_op      = 3'h6,
        clear_negative_op   = 3'h7
    } bbce_op_e;

    // gray along idle -> eval -> push -> load -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EVAL = 2'b01,
        ST_PUSH = 2'b11,
        ST_LOAD = 2'b10
    } bbce_state_e;

    function automatic logic [15:0] size_mask(input logic is_byte);
        return is_byte ? BYTE_MASK : WORD_MASK;
    endfunction

    function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        return {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
    endfunction

    function automatic logic [31:0] ext32(input logic [15:0] v);
        return {REG_RST, v};
    endfunction

endpackage
`default_nettype wire

// [bbce_exec.sv]
// execution unit for bit clear/set/test, branch, call and clear instructions
//
// What this block does
// - clear-bits writes NOT source AND destination; source is untouched.
// - set-bits writes source OR destination; source is untouched.
// - clear-bits, set-bits, zero, branch and call keep N, Z, C, V.
// - bit test ANDs operands for flags only; nothing is written.
// - bit test: N is result MSB, Z if zero, C is not Z, V cleared.
// - these bit and flag operations keep oscillator, core-off and interrupt bits.
// - branch loads the program counter with the source, any 16-bit address.
// - branch is word only; the byte flag has no effect.
// - call latches target, drops stack pointer by 2, pushes PC, loads target.
// - call pushes the following instruction address; word only.
// - zero-destination writes zero in word or byte size.
// - clear-carry clears only carry by masking the status register.
// - clear-negative clears only negative by masking the status register.
// - clear, set, test and zero have 8-bit forms besides 16-bit ones.
`timescale 1ns/1ns
`default_nettype none
module bbce_exec (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        busy,
    output var  logic        dst_we,
    output var  logic [15:0] dst_wdata,
    output var  logic        push_we,
    output var  logic [15:0] push_addr,
    output var  logic [15:0] push_data
);

    // ****************************************
    // bus slave
    // ****************************************
    logic        wait_ff;
    logic        nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] rd_mux;
    logic        req;
    logic        take;
    logic        wr_take;

    logic [2:0]  op_raw;
    bbce_pkg::bbce_op_e    op_ff;
    bbce_pkg::bbce_op_e    nxt_op;
    bbce_pkg::bbce_state_e state_ff;
    bbce_pkg::bbce_state_e nxt_state;
    logic        byte_ff;
    logic        nxt_byte;
    logic        done_ff;
    logic        nxt_done;
    logic        busy_ff;
    logic        nxt_busy;
    logic [15:0] src_ff;
    logic [15:0] nxt_src;
    logic [15:0] dst_ff;
    logic [15:0] nxt_dst;
    logic [15:0] res_ff;
    logic [15:0] nxt_res;
    logic [15:0] sr_ff;
    logic [15:0] nxt_sr;
    logic [15:0] pc_ff;
    logic [15:0] nxt_pc;
    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic [15:0] tmp_ff;
    logic [15:0] nxt_tmp;
    logic [15:0] tos_ff;
    logic [15:0] nxt_tos;
    logic        dwe_ff;
    logic        nxt_dwe;
    logic        pwe_ff;
    logic        nxt_pwe;
    logic [15:0] paddr_ff;
    logic [15:0] nxt_paddr;
    logic [15:0] pdata_ff;
    logic [15:0] nxt_pdata;
    logic [15:0] msk;
    logic [15:0] tst;
    logic        in_eval;

    assign req     = avs_read | avs_write;
    assign take    = req & ~wait_ff;
    assign wr_take = take & avs_write;
    assign msk     = bbce_pkg::size_mask(byte_ff);
    assign tst     = src_ff & dst_ff & msk;
    assign in_eval = (state_ff == bbce_pkg::ST_EVAL);
    assign op_raw  = avs_writedata[bbce_pkg::CTL_OP_MSB:bbce_pkg::CTL_OP_LSB];

    always_comb begin
        case (avs_address)
            bbce_pkg::OFS_CTRL:   rd_mux = bbce_pkg::ext32({bbce_pkg::CTL_PAD, byte_ff, op_ff});
            bbce_pkg::OFS_STATUS: rd_mux = bbce_pkg::ext32({bbce_pkg::STAT_PAD, done_ff, busy_ff});
            bbce_pkg::OFS_SRC:    rd_mux = bbce_pkg::ext32(src_ff);
            bbce_pkg::OFS_DST:    rd_mux = bbce_pkg::ext32(dst_ff);
            bbce_pkg::OFS_RESULT: rd_mux = bbce_pkg::ext32(res_ff);
            bbce_pkg::OFS_STREG:  rd_mux = bbce_pkg::ext32(sr_ff);
            bbce_pkg::OFS_PC:     rd_mux = bbce_pkg::ext32(pc_ff);
            bbce_pkg::OFS_SP:     rd_mux = bbce_pkg::ext32(sp_ff);
            bbce_pkg::OFS_TOS:    rd_mux = bbce_pkg::ext32(tos_ff);
            default:              rd_mux = bbce_pkg::ext32(bbce_pkg::REG_RST);
        endcase
    end

    // one wait cycle per access, then a one-cycle release
    always_comb begin
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        if (req && wait_ff) begin
            nxt_wait = 1'b0;
            if (avs_read) begin
                nxt_rdata = rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= bbce_pkg::ext32(bbce_pkg::REG_RST);
        end else begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // datapath and sequencer
    // ****************************************
    always_comb begin
        nxt_op    = op_ff;
        nxt_byte  = byte_ff;
        nxt_state = state_ff;
        nxt_done  = done_ff;
        nxt_src   = src_ff;
        nxt_dst   = dst_ff;
        nxt_res   = res_ff;
        nxt_sr    = sr_ff;
        nxt_pc    = pc_ff;
        nxt_sp    = sp_ff;
        nxt_tmp   = tmp_ff;
        nxt_tos   = tos_ff;
        nxt_dwe   = 1'b0;
        nxt_pwe   = 1'b0;
        nxt_paddr = paddr_ff;
        nxt_pdata = pdata_ff;
        // operand writes are refused while an operation runs
        if (wr_take) begin
            case (avs_address)
                bbce_pkg::OFS_CTRL: begin
                    if (state_ff == bbce_pkg::ST_IDLE && avs_byteenable[0]) begin
                        nxt_op    = bbce_pkg::bbce_op_e'(op_raw);
                        nxt_byte  = avs_writedata[bbce_pkg::CTL_BYTE];
                        nxt_state = bbce_pkg::ST_EVAL;
                    end
                end
                bbce_pkg::OFS_STATUS: begin
                    if (avs_byteenable[0] && avs_writedata[bbce_pkg::ST_DONE]) begin
                        nxt_done = 1'b0;
                    end
                end
                bbce_pkg::OFS_SRC: begin
                    if (state_ff == bbce_pkg::ST_IDLE) begin
                        nxt_src = bbce_pkg::be_merge(src_ff, avs_writedata, avs_byteenable);
                    end
                end
                bbce_pkg::OFS_DST: begin
                    if (state_ff == bbce_pkg::ST_IDLE) begin
                        nxt_dst = bbce_pkg::be_merge(dst_ff, avs_writedata, avs_byteenable);
                    end
                end
                bbce_pkg::OFS_STREG: begin
                    if (state_ff == bbce_pkg::ST_IDLE) begin
                        nxt_sr = bbce_pkg::be_merge(sr_ff, avs_writedata, avs_byteenable);
                    end
                end
                bbce_pkg::OFS_PC: begin
                    if (state_ff == bbce_pkg::ST_IDLE) begin
                        nxt_pc = bbce_pkg::be_merge(pc_ff, avs_writedata, avs_byteenable);
                    end
                end
                bbce_pkg::OFS_SP: begin
                    if (state_ff == bbce_pkg::ST_IDLE) begin
                        nxt_sp = bbce_pkg::be_merge(sp_ff, avs_writedata, avs_byteenable);
                    end
                end
                default: begin
                end
            endcase
        end
        // completion is applied after a software clear, so a finish wins
        case (state_ff)
            bbce_pkg::ST_IDLE: begin
            end
            bbce_pkg::ST_EVAL: begin
                nxt_state = bbce_pkg::ST_IDLE;
                nxt_done  = 1'b1;
                case (op_ff)
                    bbce_pkg::clear_bits_op: begin
                        nxt_res = ~src_ff & dst_ff & msk;
                        nxt_dwe = 1'b1;
                    end
                    bbce_pkg::set_bits_op: begin
                        nxt_res = (src_ff | dst_ff) & msk;
                        nxt_dwe = 1'b1;
                    end
                    bbce_pkg::test_bits_op: begin
                        // only the four flags move; mode bits stay
                        nxt_sr[bbce_pkg::SR_N] = byte_ff ? tst[bbce_pkg::BYTE_MSB]
                                                         : tst[bbce_pkg::WORD_MSB];
                        nxt_sr[bbce_pkg::SR_Z] = (tst == bbce_pkg::REG_RST);
                        nxt_sr[bbce_pkg::SR_C] = (tst != bbce_pkg::REG_RST);
                        nxt_sr[bbce_pkg::SR_V] = 1'b0;
                    end
                    bbce_pkg::branch_op: begin
                        nxt_pc = src_ff;
                    end
                    bbce_pkg::call_op: begin
                        nxt_tmp   = dst_ff;
                        nxt_state = bbce_pkg::ST_PUSH;
                        nxt_done  = done_ff;
                    end
                    bbce_pkg::zero_destination_op: begin
                        nxt_res = bbce_pkg::REG_RST;
                        nxt_dwe = 1'b1;
                    end
                    bbce_pkg::clear_carry_op: begin
                        nxt_sr = sr_ff & ~bbce_pkg::CARRY_MASK;
                    end
                    bbce_pkg::clear_negative_op: begin
                        nxt_sr = sr_ff & ~bbce_pkg::NEG_MASK;
                    end
                    default: begin
                    end
                endcase
            end
            bbce_pkg::ST_PUSH: begin
                // pc already holds the address after the call
                nxt_sp    = sp_ff - bbce_pkg::STACK_STEP;
                nxt_paddr = sp_ff - bbce_pkg::STACK_STEP;
                nxt_pdata = pc_ff;
                nxt_tos   = pc_ff;
                nxt_pwe   = 1'b1;
                nxt_state = bbce_pkg::ST_LOAD;
            end
            bbce_pkg::ST_LOAD: begin
                nxt_pc    = tmp_ff;
                nxt_done  = 1'b1;
                nxt_state = bbce_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = bbce_pkg::ST_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != bbce_pkg::ST_IDLE);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_ff    <= bbce_pkg::clear_bits_op;
            byte_ff  <= 1'b0;
            state_ff <= bbce_pkg::ST_IDLE;
            done_ff  <= 1'b0;
            busy_ff  <= 1'b0;
            src_ff   <= bbce_pkg::REG_RST;
            dst_ff   <= bbce_pkg::REG_RST;
            res_ff   <= bbce_pkg::REG_RST;
            sr_ff    <= bbce_pkg::REG_RST;
            pc_ff    <= bbce_pkg::REG_RST;
            sp_ff    <= bbce_pkg::REG_RST;
            tmp_ff   <= bbce_pkg::REG_RST;
            tos_ff   <= bbce_pkg::REG_RST;
            dwe_ff   <= 1'b0;
            pwe_ff   <= 1'b0;
            paddr_ff <= bbce_pkg::REG_RST;
            pdata_ff <= bbce_pkg::REG_RST;
        end else begin
            op_ff    <= nxt_op;
            byte_ff  <= nxt_byte;
            state_ff <= nxt_state;
            done_ff  <= nxt_done;
            busy_ff  <= nxt_busy;
            src_ff   <= nxt_src;
            dst_ff   <= nxt_dst;
            res_ff   <= nxt_res;
            sr_ff    <= nxt_sr;
            pc_ff    <= nxt_pc;
            sp_ff    <= nxt_sp;
            tmp_ff   <= nxt_tmp;
            tos_ff   <= nxt_tos;
            dwe_ff   <= nxt_dwe;
            pwe_ff   <= nxt_pwe;
            paddr_ff <= nxt_paddr;
            pdata_ff <= nxt_pdata;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign busy            = busy_ff;
    assign dst_we          = dwe_ff;
    assign dst_wdata       = res_ff;
    assign push_we         = pwe_ff;
    assign push_addr       = paddr_ff;
    assign push_data       = pdata_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_clear_bits_val: assert property (
        in_eval && op_ff == bbce_pkg::clear_bits_op |=>
            dst_we && dst_wdata == ($past(~src_ff & dst_ff & msk)) && $stable(src_ff))
        else $error("clear-bits result wrong");
    a_set_bits_val: assert property (
        in_eval && op_ff == bbce_pkg::set_bits_op |=>
            dst_we && dst_wdata == $past((src_ff | dst_ff) & msk) && $stable(src_ff))
        else $error("set-bits result wrong");
    a_flags_kept: assert property (
        in_eval && op_ff inside {bbce_pkg::clear_bits_op, bbce_pkg::set_bits_op,
            bbce_pkg::zero_destination_op, bbce_pkg::branch_op, bbce_pkg::call_op}
        |=> $stable(sr_ff) [*3])
        else $error("flags moved on a flag-neutral operation");
    a_test_no_write: assert property (
        in_eval && op_ff == bbce_pkg::test_bits_op |=>
            !dst_we && $stable(res_ff) && $stable(dst_ff) && $stable(src_ff))
        else $error("bit test wrote a result");
    a_test_flags: assert property (
        in_eval && op_ff == bbce_pkg::test_bits_op |=>
            sr_ff[bbce_pkg::SR_Z] == ($past(tst) == bbce_pkg::REG_RST)
            && sr_ff[bbce_pkg::SR_C] != sr_ff[bbce_pkg::SR_Z] && !sr_ff[bbce_pkg::SR_V])
        else $error("bit test flags wrong");
    a_mode_bits_kept: assert property (
        in_eval && op_ff != bbce_pkg::branch_op && op_ff != bbce_pkg::call_op |=>
            $stable(sr_ff[bbce_pkg::SR_OSC_OFF:bbce_pkg::SR_GIE]))
        else $error("mode bits changed");
    a_branch_pc: assert property (
        in_eval && op_ff == bbce_pkg::branch_op |=> pc_ff == $past(src_ff) && !push_we)
        else $error("branch target not loaded");
    a_branch_word: assert property (
        in_eval && op_ff == bbce_pkg::branch_op && byte_ff |=>
            pc_ff[bbce_pkg::WORD_MSB:bbce_pkg::BYTE_MSB+1] == $past(src_ff[15:8]))
        else $error("byte form cut the branch target");
    a_call_seq: assert property (
        in_eval && op_ff == bbce_pkg::call_op |=> ##1
            (sp_ff == $past(sp_ff, 2) - bbce_pkg::STACK_STEP && push_we)
            ##1 (pc_ff == $past(dst_ff, 3) && busy == 1'b0))
        else $error("call sequence wrong");
    a_call_push: assert property (
        push_we |-> push_data == pc_ff && push_addr == sp_ff && state_ff == bbce_pkg::ST_LOAD)
        else $error("pushed word is not the return address");
    a_zero_dst: assert property (
        in_eval && op_ff == bbce_pkg::zero_destination_op |=>
            dst_we && dst_wdata == bbce_pkg::REG_RST)
        else $error("zero-destination wrote nonzero");
    a_clear_carry: assert property (
        in_eval && op_ff == bbce_pkg::clear_carry_op |=>
            sr_ff == ($past(sr_ff) & ~bbce_pkg::CARRY_MASK))
        else $error("clear-carry wrong");
    a_clear_neg: assert property (
        in_eval && op_ff == bbce_pkg::clear_negative_op |=>
            sr_ff == ($past(sr_ff) & ~bbce_pkg::NEG_MASK))
        else $error("clear-negative wrong");
    a_byte_upper: assert property (
        in_eval && byte_ff && op_ff inside {bbce_pkg::clear_bits_op,
            bbce_pkg::set_bits_op} |=> dst_wdata[15:8] == bbce_pkg::CTL_PAD[7:0])
        else $error("byte form upper bits not zero");
    a_byte_test_neg: assert property (
        in_eval && byte_ff && op_ff == bbce_pkg::test_bits_op |=>
            sr_ff[bbce_pkg::SR_N] == $past(src_ff[7] & dst_ff[7]))
        else $error("byte test negative wrong");

endmodule // bbce_exec
`default_nettype wire

// [bbce_exec_test.sv]
// self-checking bench for the bit/branch/call/clear execution block
`timescale 1ns/1ns
`default_nettype none
module bbce_exec_test;
    logic        ref_clk;
    logic        rst;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        busy;
    logic        dst_we;
    logic [15:0] dst_wdata;
    logic        push_we;
    logic [15:0] push_addr;
    logic [15:0] push_data;
    int          n_fail;
    int          checks_done;
    int          seed;
    logic [31:0] rq[$];
    logic [31:0] wq[$];
    logic [31:0] pq[$];

    bbce_exec uut (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .busy(busy), .dst_we(dst_we),
        .dst_wdata(dst_wdata), .push_we(push_we), .push_addr(push_addr),
        .push_data(push_data)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // outputs are registered, so mid-cycle sampling is race free
    always @(negedge ref_clk) begin
        if (avs_read && !avs_waitrequest) begin
            chk(avs_readdata, rq.size() > 0 ? rq.pop_front() : ~avs_readdata);
        end
        if (dst_we) begin
            chk({16'h0000, dst_wdata}, wq.size() > 0 ? wq.pop_front() : 32'hffff_ffff);
        end
        if (push_we) begin
            chk({push_addr, push_data}, pq.size() > 0 ? pq.pop_front() : 32'hffff_ffff);
        end
    end

    // ****************************************
    // avalon master
    // ****************************************
    task automatic bus(input logic is_rd, input logic [5:0] a, input logic [31:0] wd);
        int k;
        @(posedge ref_clk);
        avs_read      <= is_rd;
        avs_write     <= !is_rd;
        avs_address   <= a;
        avs_writedata <= wd;
        k = 0;
        // waitrequest is registered: at the edge it still shows the settled value
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            wrap_up();
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        bus(1'b0, a, {16'h0000, v});
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        rq.push_back({16'h0000, e});
        bus(1'b1, a, 32'h0000_0000);
    endtask

    // ****************************************
    // one operation with random operands
    // ****************************************
    task automatic run_op(input logic [2:0] op, input logic b);
        logic [15:0] s, d, sr, pc, sp, m, r, esr, epc;
        int          k;
        s   = 16'($random(seed));
        d   = 16'($random(seed));
        sr  = 16'($random(seed));
        pc  = 16'($random(seed));
        sp  = 16'($random(seed));
        m   = b ? 16'h00ff : 16'hffff;
        esr = sr;
        epc = pc;
        r   = 16'h0000;
        wr(bbce_pkg::OFS_SRC, s);
        wr(bbce_pkg::OFS_DST, d);
        wr(bbce_pkg::OFS_STREG, sr);
        wr(bbce_pkg::OFS_PC, pc);
        wr(bbce_pkg::OFS_SP, sp);
        case (op)
            3'h0: r = ~s & d & m;
            3'h1: r = (s | d) & m;
            3'h2: begin
                r = s & d & m;
                esr[bbce_pkg::SR_N] = b ? r[7] : r[15];
                esr[bbce_pkg::SR_Z] = (r == 16'h0000);
                esr[bbce_pkg::SR_C] = (r != 16'h0000);
                esr[bbce_pkg::SR_V] = 1'b0;
            end
            3'h3: epc = s;
            3'h4: begin
                epc = d;
                pq.push_back({sp - 16'h0002, pc});
            end
            3'h6: esr = sr & ~16'h0001;
            3'h7: esr = sr & ~16'h0004;
            default: r = 16'h0000;
        endcase
        if (op < 3'h2 || op == 3'h5) begin
            wq.push_back({16'h0000, r});
        end
        wr(bbce_pkg::OFS_CTRL, {12'h000, b, op});
        // a write while a call is still busy must be dropped
        if (op == 3'h4) begin
            wr(bbce_pkg::OFS_SRC, ~s);
        end
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (busy !== 1'b0 && k < 20);
        if (busy !== 1'b0) begin
            n_fail++;
            wrap_up();
        end
        rd(bbce_pkg::OFS_STREG, esr);
        rd(bbce_pkg::OFS_PC, epc);
        rd(bbce_pkg::OFS_SRC, s);
        if (op < 3'h2 || op == 3'h5) begin
            rd(bbce_pkg::OFS_RESULT, r);
        end
        if (op == 3'h4) begin
            rd(bbce_pkg::OFS_SP, sp - 16'h0002);
            rd(bbce_pkg::OFS_TOS, pc);
        end
        rd(bbce_pkg::OFS_STATUS, 16'h0002);
        wr(bbce_pkg::OFS_STATUS, 16'h0002);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed           = 22;
        n_fail         = 0;
        checks_done    = 0;
        rst            = 1'b1;
        avs_address    = 6'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hf;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rd(6'(a * 4), 16'h0000);
        end
        wr(6'h24, 16'hffff);
        rd(6'h24, 16'h0000);
        wr(bbce_pkg::OFS_RESULT, 16'hffff);
        rd(bbce_pkg::OFS_RESULT, 16'h0000);
        // lane 0 only reaches the low byte; control without lane 0 starts nothing
        avs_byteenable <= 4'h1;
        wr(bbce_pkg::OFS_SRC, 16'hffff);
        avs_byteenable <= 4'h0;
        wr(bbce_pkg::OFS_CTRL, 16'h0001);
        avs_byteenable <= 4'hf;
        rd(bbce_pkg::OFS_SRC, 16'h00ff);
        rd(bbce_pkg::OFS_CTRL, 16'h0000);
        rd(bbce_pkg::OFS_STATUS, 16'h0000);
        for (int rep = 0; rep < 3; rep++) begin
            for (int op = 0; op < 8; op++) begin
                run_op(3'(op), 1'b0);
                run_op(3'(op), 1'b1);
            end
        end
        rd(bbce_pkg::OFS_STATUS, 16'h0000);
        repeat (3) @(posedge ref_clk);
        chk(32'(rq.size() + wq.size() + pq.size()), 32'h0000_0000);
        wrap_up();
    end
endmodule // bbce_exec_test
`default_nettype wire
